//--- core/mpo_offset_speed.sv
// offset speed block: raise/lower ramp, modes, setpoint sum, loop selection
`timescale 1ns/1ps

// Functional notes
// RQ1 - mode 0..6 selects behaviour; 0 is default and disables the offset
// RQ2 - nonzero modes ramp up on raise, down on lower, clamped to speed limit
// RQ3 - modes 2, 4, 6 zero the offset when both inputs are active
// RQ4 - modes 3 and 4 keep the offset across mains loss and restore it
// RQ5 - modes 5 and 6 zero the offset when start is withdrawn
// RQ6 - raise rate settable 0..32760 rpm/s, default 1000
// RQ7 - lower rate settable 0..32760 rpm/s, default 1000
// RQ8 - offset readable as signed rpm, -32764..32764, resets to zero
// RQ9 - setpoint output is analog base plus offset
// RQ10 - outside party assigns one input to raise, another to lower
// RQ11 - torque, speed and position loop modes are selectable
// RQ12 - speed mode runs speed and torque loops, position loop decoupled
// RQ13 - acceleration feedforward weighted by percentage, default 100
// RQ14 - optional friction torque term added to feedforward
// RQ15 - no input and no reset condition leaves the offset unchanged; code still clamps it when the speed limit drops below it
// RQ16 - steps applied on a fixed tick, rate times tick, saturating
module mpo_offset_speed (
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	input  wire logic [3:0]         reg_addr_i,
	input  wire logic [31:0]        reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic [31:0]             reg_rdata_o,
	input  wire logic               raise_input_i,
	input  wire logic               lower_input_i,
	input  wire logic               start_cmd_i,
	input  wire logic               mains_ok_i,
	input  wire logic signed [15:0] analog_base_input_i,
	input  wire logic signed [15:0] accel_ff_i,
	input  wire logic               save_valid_i,
	input  wire logic signed [15:0] save_speed_i,
	output logic                    save_wr_o,
	output logic signed [15:0]      save_speed_o,
	output logic signed [15:0]      offset_speed_value_o,
	output logic signed [15:0]      speed_setpoint_o,
	output logic signed [15:0]      feedforward_o,
	output logic                    torque_loop_en_o,
	output logic                    speed_loop_en_o,
	output logic                    position_loop_en_o
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [2:0]         offset_mode_select;
		logic [14:0]        offset_raise_rate;
		logic [14:0]        offset_lower_rate;
		logic [15:0]        rated_motor_speed;
		logic [9:0]         max_speed_percent;
		logic [1:0]         loop_sel;
		logic               fric_en;
		logic [9:0]         feedforward_weight;
		logic [15:0]        friction_comp_torque;
		logic signed [31:0] offset_acc;
		logic [17:0]        tick_cnt;
		logic               start_q;
		logic               mains_q;
		logic               restored;
		logic [31:0]        rdata;
		logic               save_wr;
		logic signed [15:0] save_speed;
		logic signed [15:0] offset_out;
		logic signed [15:0] setpoint;
		logic signed [15:0] ff_out;
		logic               tq_en;
		logic               sp_en;
		logic               ps_en;
	} mpo_state_s;

	mpo_state_s st;
	mpo_state_s next_st;

	mpo_pkg::mpo_req_s  req;
	mpo_pkg::mpo_save_s saved;

	logic               raise_s;
	logic               lower_s;
	logic               start_s;
	logic               mains_s;
	logic               tick;
	logic signed [31:0] limit_acc;
	logic signed [31:0] up_step;
	logic signed [31:0] dn_step;
	logic signed [31:0] up_res;
	logic signed [31:0] dn_res;
	logic [31:0]        lim_rpm;
	logic signed [16:0] sum_sp;
	logic signed [31:0] ff_prod;
	logic signed [31:0] ff_sum;
	logic               mode_on;
	logic               mode_retain;
	logic               mode_both_zero;
	logic               mode_start_zero;

	assign req   = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
	assign saved = '{valid: save_valid_i, speed: save_speed_i};

	////////////////////////////////////////////////////////////////////////////
	// mode decode

	// offset function enabled in modes 1 to 6
	assign mode_on         = (st.offset_mode_select != mpo_pkg::MODE_OFF); // RQ1
	// retention across mains loss in modes 3 and 4
	assign mode_retain     = (st.offset_mode_select == 3'h3)
		|| (st.offset_mode_select == 3'h4); // RQ4
	// both inputs zero the offset in modes 2, 4 and 6
	assign mode_both_zero  = (st.offset_mode_select == 3'h2)
		|| (st.offset_mode_select == 3'h4)
		|| (st.offset_mode_select == 3'h6); // RQ3
	// withdrawn start zeroes the offset in modes 5 and 6
	assign mode_start_zero = (st.offset_mode_select == 3'h5)
		|| (st.offset_mode_select == 3'h6); // RQ5

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// raise, lower, start and mains pass two flops before any use
	mpo_sync u_sync_raise (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (raise_input_i),
		.level_o    (raise_s)
	);

	mpo_sync u_sync_lower (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (lower_input_i),
		.level_o    (lower_s)
	);

	mpo_sync u_sync_start (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (start_cmd_i),
		.level_o    (start_s)
	);

	mpo_sync u_sync_mains (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (mains_ok_i),
		.level_o    (mains_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// limit and step arithmetic

	// speed limit = rated speed x percent / 100, capped at display range
	always_comb begin
		lim_rpm = (32'(st.rated_motor_speed) * 32'(st.max_speed_percent))
			/ 32'(mpo_pkg::PCT_DIV); // RQ2
		if (lim_rpm > 32'(mpo_pkg::SPEED_MAX)) begin
			lim_rpm = 32'(mpo_pkg::SPEED_MAX); // RQ8
		end
		limit_acc = signed'(lim_rpm << mpo_pkg::FRAC_W);
	end

	// step per tick = rate / ticks per second, in fractional rpm
	assign up_step = signed'((32'(st.offset_raise_rate) << mpo_pkg::FRAC_W)
		/ 32'(mpo_pkg::TICKS_PER_S)); // RQ6 RQ16
	assign dn_step = -signed'((32'(st.offset_lower_rate) << mpo_pkg::FRAC_W)
		/ 32'(mpo_pkg::TICKS_PER_S)); // RQ7 RQ16

	// up and down candidates, one of them taken on the tick
	mpo_sat_step u_step_up (
		.value_i  (st.offset_acc),
		.step_i   (up_step),
		.limit_i  (limit_acc),
		.result_o (up_res)
	);

	mpo_sat_step u_step_dn (
		.value_i  (st.offset_acc),
		.step_i   (dn_step),
		.limit_i  (limit_acc),
		.result_o (dn_res)
	);

	// fixed ramp tick, one cycle in every tick period
	assign tick = (st.tick_cnt == 18'(mpo_pkg::TICK_CYC - 1)); // RQ16

	// setpoint sum with saturation to display range
	always_comb begin
		sum_sp = 17'(analog_base_input_i) + 17'(st.offset_out); // RQ9
	end

	// weighted acceleration feedforward plus optional friction term
	always_comb begin
		ff_prod = (32'(accel_ff_i) * signed'(32'(st.feedforward_weight)))
			/ signed'(32'(mpo_pkg::PCT_DIV)); // RQ13
		ff_sum  = ff_prod;
		if (st.fric_en) begin
			ff_sum = ff_prod + signed'(32'(st.friction_comp_torque)); // RQ14
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	// one pass builds the whole next state image
	always_comb begin
		next_st          = st;
		next_st.start_q  = start_s;
		next_st.mains_q  = mains_s;
		next_st.save_wr  = 1'b0;
		next_st.tick_cnt = tick ? '0 : st.tick_cnt + 18'h00001;

		// register writes
		if (req.wr) begin
			unique case (req.addr)
				mpo_pkg::REG_MODE: begin
					if (req.wdata[2:0] <= mpo_pkg::MODE_MAX) begin
						next_st.offset_mode_select = req.wdata[2:0]; // RQ1
					end
				end
				mpo_pkg::REG_RAISE: begin
					next_st.offset_raise_rate = (req.wdata[14:0] > mpo_pkg::RATE_MAX)
						? mpo_pkg::RATE_MAX : req.wdata[14:0]; // RQ6
				end
				mpo_pkg::REG_LOWER: begin
					next_st.offset_lower_rate = (req.wdata[14:0] > mpo_pkg::RATE_MAX)
						? mpo_pkg::RATE_MAX : req.wdata[14:0]; // RQ7
				end
				mpo_pkg::REG_RATED: next_st.rated_motor_speed = req.wdata[15:0];
				mpo_pkg::REG_MAXPCT: next_st.max_speed_percent = req.wdata[9:0];
				mpo_pkg::REG_LOOP: begin
					if (req.wdata[1:0] != 2'h3) begin
						next_st.loop_sel = req.wdata[1:0]; // RQ11
					end
					next_st.fric_en = req.wdata[mpo_pkg::LOOP_FRIC_BIT]; // RQ14
				end
				mpo_pkg::REG_FFWEIGHT: next_st.feedforward_weight = req.wdata[9:0];
				mpo_pkg::REG_FRICTION: next_st.friction_comp_torque = req.wdata[15:0];
				default: ;
			endcase
		end

		// offset ramp and reset conditions, highest priority first
		if (!mode_on) begin
			next_st.offset_acc = '0; // RQ1
		end else if (!st.restored && saved.valid && mode_retain) begin
			next_st.offset_acc = 32'(saved.speed) <<< mpo_pkg::FRAC_W; // RQ4
			next_st.restored   = 1'b1;
		end else if (raise_s && lower_s && mode_both_zero) begin
			next_st.offset_acc = '0; // RQ3
		end else if (st.start_q && !start_s && mode_start_zero) begin
			next_st.offset_acc = '0; // RQ5
		end else if (tick && raise_s && !lower_s) begin
			next_st.offset_acc = up_res; // RQ2 RQ16
		end else if (tick && lower_s && !raise_s) begin
			next_st.offset_acc = dn_res; // RQ2 RQ16
		end else if (st.offset_acc > limit_acc) begin
			next_st.offset_acc = limit_acc; // RQ2
		end else if (st.offset_acc < -limit_acc) begin
			next_st.offset_acc = -limit_acc; // RQ2
		end // RQ15

		// restore is offered once, in the first retaining cycle after reset
		if (mode_retain) begin
			next_st.restored = 1'b1;
		end

		// save image on falling mains in retaining modes
		if (st.mains_q && !mains_s && mode_retain) begin
			next_st.save_wr    = 1'b1; // RQ4
			next_st.save_speed = st.offset_out;
		end

		// registered outputs
		next_st.offset_out = 16'(st.offset_acc >>> mpo_pkg::FRAC_W); // RQ8
		if (sum_sp > 17'(mpo_pkg::SPEED_MAX)) begin
			next_st.setpoint = mpo_pkg::SPEED_MAX; // RQ9
		end else if (sum_sp < 17'(mpo_pkg::SPEED_MIN)) begin
			next_st.setpoint = mpo_pkg::SPEED_MIN;
		end else begin
			next_st.setpoint = sum_sp[15:0];
		end
		next_st.ff_out = 16'(ff_sum);
		next_st.tq_en = 1'b1; // torque loop always active
		next_st.sp_en = (st.loop_sel != 2'(mpo_pkg::LOOP_TORQUE)); // RQ11
		next_st.ps_en = (st.loop_sel == 2'(mpo_pkg::LOOP_POSITION)); // RQ12

		// register reads, data in the following cycle
		next_st.rdata = '0;
		if (req.rd) begin
			unique case (req.addr)
				mpo_pkg::REG_MODE:     next_st.rdata = 32'(st.offset_mode_select);
				mpo_pkg::REG_RAISE:    next_st.rdata = 32'(st.offset_raise_rate);
				mpo_pkg::REG_LOWER:    next_st.rdata = 32'(st.offset_lower_rate);
				mpo_pkg::REG_OFFSET:   next_st.rdata = 32'(st.offset_out); // RQ8
				mpo_pkg::REG_RATED:    next_st.rdata = 32'(st.rated_motor_speed);
				mpo_pkg::REG_MAXPCT:   next_st.rdata = 32'(st.max_speed_percent);
				mpo_pkg::REG_LOOP:     next_st.rdata = {29'h0, st.fric_en, st.loop_sel};
				mpo_pkg::REG_FFWEIGHT: next_st.rdata = 32'(st.feedforward_weight);
				mpo_pkg::REG_FRICTION: next_st.rdata = 32'(st.friction_comp_torque);
				mpo_pkg::REG_SETPOINT: next_st.rdata = 32'(st.setpoint);
				mpo_pkg::REG_FFOUT:    next_st.rdata = 32'(st.ff_out);
				default:               next_st.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// asynchronous reset to power-on defaults
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st                      <= '0;
			st.offset_mode_select   <= mpo_pkg::MODE_RESET; // RQ1
			st.offset_raise_rate    <= mpo_pkg::RATE_RESET; // RQ6
			st.offset_lower_rate    <= mpo_pkg::RATE_RESET; // RQ7
			st.rated_motor_speed    <= mpo_pkg::RATED_RESET;
			st.max_speed_percent    <= mpo_pkg::PCT_RESET;
			st.loop_sel             <= 2'(mpo_pkg::LOOP_SPEED);
			st.feedforward_weight   <= mpo_pkg::WEIGHT_RESET; // RQ13
			st.offset_out           <= mpo_pkg::SPEED_RESET; // RQ8
			st.tq_en                <= 1'b1;
			st.sp_en                <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata_o          = st.rdata;
	assign save_wr_o            = st.save_wr;
	assign save_speed_o         = st.save_speed;
	assign offset_speed_value_o = st.offset_out;
	assign speed_setpoint_o     = st.setpoint;
	assign feedforward_o        = st.ff_out;
	assign torque_loop_en_o     = st.tq_en;
	assign speed_loop_en_o      = st.sp_en;
	assign position_loop_en_o   = st.ps_en;
endmodule

//--- core/mpo_pkg.sv
// package for the offset speed block: constants, enums and carrier structs
package mpo_pkg;

	// mode selector range
	localparam logic [2:0]  MODE_OFF      = 3'h0;
	localparam logic [2:0]  MODE_MAX      = 3'h6;
	localparam logic [2:0]  MODE_RESET    = 3'h0;

	// ramp rate range and defaults, rpm per second
	localparam logic [14:0] RATE_MAX      = 15'h7ff8;
	localparam logic [14:0] RATE_RESET    = 15'h03e8;

	// offset display range, rpm
	localparam logic signed [15:0] SPEED_MAX   = 16'sh7ffc;
	localparam logic signed [15:0] SPEED_MIN   = -16'sh7ffc;
	localparam logic signed [15:0] SPEED_RESET = 16'sh0000;

	// speed-limit and feedforward-weight reset values, percent divisor
	localparam logic [15:0] RATED_RESET   = 16'h0bb8;
	localparam logic [9:0]  PCT_RESET     = 10'h064;
	localparam logic [9:0]  WEIGHT_RESET  = 10'h064;
	localparam logic [9:0]  PCT_DIV       = 10'h064;

	// ramp tick: 1 ms at the core clock
	localparam int          CLK_HZ        = 250000000;
	localparam int          TICK_US       = 1000;
	localparam int          TICK_CYC      = CLK_HZ / 1000000 * TICK_US;
	localparam int          TICKS_PER_S   = 1000000 / TICK_US;

	// fractional accumulator width below one rpm
	localparam int          FRAC_W        = 10;

	// register map (word offsets on the plain port)
	localparam logic [3:0]  REG_MODE      = 4'h0;
	localparam logic [3:0]  REG_RAISE     = 4'h1;
	localparam logic [3:0]  REG_LOWER     = 4'h2;
	localparam logic [3:0]  REG_OFFSET    = 4'h3;
	localparam logic [3:0]  REG_RATED     = 4'h4;
	localparam logic [3:0]  REG_MAXPCT    = 4'h5;
	localparam logic [3:0]  REG_LOOP      = 4'h6;
	localparam logic [3:0]  REG_FFWEIGHT  = 4'h7;
	localparam logic [3:0]  REG_FRICTION  = 4'h8;
	localparam logic [3:0]  REG_SETPOINT  = 4'h9;
	localparam logic [3:0]  REG_FFOUT     = 4'ha;

	// loop-mode field: bits [1:0] select, bit 2 friction enable
	localparam int          LOOP_FRIC_BIT = 2;

	typedef enum logic [1:0] {
		LOOP_TORQUE,
		LOOP_SPEED,
		LOOP_POSITION
	} mpo_loop_e;

	// register-port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} mpo_req_s;

	// saved offset image for mains failure
	typedef struct packed {
		logic               valid;
		logic signed [15:0] speed;
	} mpo_save_s;
endpackage

//--- core/mpo_sync.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module mpo_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	typedef struct packed {
		logic s1;
		logic s2;
	} mpo_sync_s;

	mpo_sync_s st;
	mpo_sync_s next_st;

	// first stage is read only by the second
	always_comb begin
		next_st.s1 = pin_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.s2;
endmodule

//--- core/mpo_sat_step.sv
// saturating signed add of a ramp step with symmetric limit
`timescale 1ns/1ps
module mpo_sat_step (
	input  wire logic signed [31:0] value_i,
	input  wire logic signed [31:0] step_i,
	input  wire logic signed [31:0] limit_i,
	output logic signed [31:0]      result_o
);
	logic signed [32:0] sum;

	// widened sum cannot wrap, then clamp to plus or minus limit
	always_comb begin
		sum = 33'(value_i) + 33'(step_i);
		if (sum > 33'(limit_i)) begin
			result_o = limit_i;
		end else if (sum < -33'(limit_i)) begin
			result_o = -limit_i;
		end else begin
			result_o = sum[31:0];
		end
	end
endmodule

//--- verification/mpo_monitor.sv
// port-level concurrent checks for the offset speed block
`timescale 1ns/1ps
module mpo_monitor (
	input wire logic               core_clk_i,
	input wire logic               rst_i,
	input wire logic [3:0]         reg_addr_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [31:0]        reg_rdata_o,
	input wire logic               mains_ok_i,
	input wire logic signed [15:0] analog_base_input_i,
	input wire logic               save_wr_o,
	input wire logic signed [15:0] offset_speed_value_o,
	input wire logic signed [15:0] speed_setpoint_o,
	input wire logic               torque_loop_en_o,
	input wire logic               speed_loop_en_o,
	input wire logic               position_loop_en_o
);
	logic signed [16:0] sum;
	logic signed [15:0] sat;
	logic               loop_wr;
	// expected setpoint: base plus offset, clipped to the display range
	assign sum = {analog_base_input_i[15], analog_base_input_i}
		+ {offset_speed_value_o[15], offset_speed_value_o};
	assign sat = (sum > 17'sh07ffc) ? mpo_pkg::SPEED_MAX :
		(sum < -17'sh07ffc) ? mpo_pkg::SPEED_MIN : sum[15:0];
	assign loop_wr = reg_wr_i && (reg_addr_i == mpo_pkg::REG_LOOP);

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data not zero outside read answer");
	a_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'hb
		|-> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
	a_setpoint_sum: assert property (($stable(analog_base_input_i)
		&& $stable(offset_speed_value_o))[*6] |-> speed_setpoint_o == sat)
		else $error("setpoint is not base plus offset");
	a_setpoint_range: assert property (speed_setpoint_o >= mpo_pkg::SPEED_MIN
		&& speed_setpoint_o <= mpo_pkg::SPEED_MAX) else $error("setpoint out of range");
	a_offset_range: assert property (offset_speed_value_o >= mpo_pkg::SPEED_MIN
		&& offset_speed_value_o <= mpo_pkg::SPEED_MAX) else $error("offset out of range");
	a_torque_on: assert property (torque_loop_en_o)
		else $error("torque loop disabled");
	a_loop_cause: assert property (($changed(speed_loop_en_o)
		|| $changed(position_loop_en_o)) |-> ($past(loop_wr) || $past(loop_wr, 2)))
		else $error("loop enable changed without loop write");
	a_save_pulse: assert property (save_wr_o |=> !save_wr_o)
		else $error("save strobe longer than one cycle");
	a_save_cause: assert property (save_wr_o |-> !$past(mains_ok_i, 2)
		&& $past(mains_ok_i, 4)) else $error("save strobe without mains failure");
endmodule

bind mpo_offset_speed mpo_monitor u_mon (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .mains_ok_i, .analog_base_input_i, .save_wr_o,
	.offset_speed_value_o, .speed_setpoint_o, .torque_loop_en_o, .speed_loop_en_o,
	.position_loop_en_o);

//--- verification/mpo_store_model.sv
// nonvolatile offset store on the far side of the block
`timescale 1ns/1ps
module mpo_store_model #(
	parameter logic signed [15:0] PRELOAD = 16'sh0064
) (
	input wire logic               core_clk_i,
	input wire logic               save_wr_i,
	input wire logic signed [15:0] save_speed_i,
	output logic                   save_valid_o,
	output logic signed [15:0]     save_speed_o
);
	// content survives block resets, so the store has no reset
	initial begin
		save_valid_o = 1'b1;
		save_speed_o = PRELOAD;
	end
	// capture the offset on each save strobe
	always @(posedge core_clk_i) begin
		if (save_wr_i) begin
			save_speed_o <= save_speed_i;
			save_valid_o <= 1'b1;
		end
	end
endmodule

//--- verification/mpo_offset_speed_tb.sv
// self-checking bench for the offset speed block
`timescale 1ns/1ps
module mpo_offset_speed_tb;
	logic               core_clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic [3:0]         addr = 4'h0;
	logic [31:0]        wdata = 32'h0;
	logic               wr_s = 1'b0;
	logic               rd_s = 1'b0;
	logic               up = 1'b0;
	logic               dn = 1'b0;
	logic               start = 1'b1;
	logic               mains = 1'b1;
	logic signed [15:0] base = 16'sh0000;
	logic signed [15:0] ff_in = 16'sh00c8;
	logic               sv_valid, sv_wr, tq, sp, ps;
	logic signed [15:0] sv_in, sv_out, offs, setp, ffo;
	logic [31:0]        rdata, v;
	int                 miscompares = 0;
	int                 samples_checked = 0;
	logic [3:0]         da [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb};
	logic [31:0]        dv [10] = '{32'h0, 32'h3e8, 32'h3e8, 32'h0, 32'hbb8, 32'h64, 32'h1,
		32'h64, 32'h0, 32'h0};

	always #2 core_clk_i = ~core_clk_i;

	mpo_offset_speed dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.raise_input_i(up), .lower_input_i(dn), .start_cmd_i(start), .mains_ok_i(mains),
		.analog_base_input_i(base), .accel_ff_i(ff_in), .save_valid_i(sv_valid),
		.save_speed_i(sv_out), .save_wr_o(sv_wr), .save_speed_o(sv_in),
		.offset_speed_value_o(offs), .speed_setpoint_o(setp), .feedforward_o(ffo),
		.torque_loop_en_o(tq), .speed_loop_en_o(sp), .position_loop_en_o(ps));
	mpo_store_model store (.core_clk_i(core_clk_i), .save_wr_i(sv_wr),
		.save_speed_i(sv_in), .save_valid_o(sv_valid), .save_speed_o(sv_out));

	////////////////////////////////////////////////////////////////////////////////
	task results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task rst_seq();
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge core_clk_i);
		wr_s <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge core_clk_i);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task wrd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e, input string n);
		wr(a, d);
		rd(a, v);
		chk(n, v, e);
	endtask
	// raise and lower sit on separate pins
	task pins(input logic r, input logic l, input logic s, input logic m);
		@(posedge core_clk_i);
		up <= r;
		dn <= l;
		start <= s;
		mains <= m;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog on the whole run
	initial begin
		repeat (100000) @(posedge core_clk_i);
		miscompares++;
		results();
	end

	// main sequence
	initial begin
		rst_seq();
		for (int i = 0; i < 10; i++) begin
			rd(da[i], v);
			chk("reset value", v, dv[i]);
		end
		wrd(4'h0, 32'h7, 32'h0, "mode 7 ignored");
		wrd(4'h1, 32'hffff, 32'h7ff8, "raise rate clamp");
		wrd(4'h2, 32'h0, 32'h0, "lower rate zero");
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(4'h6, i);
			cyc(3);
			chk("position loop", ps, i >= 2);
			chk("torque loop", tq, 1'b1);
			if (i < 2)
				chk("speed loop", sp, i);
		end
		wr(4'h7, 32'h32);
		wr(4'h6, 32'h1);
		cyc(4);
		chk("weighted ff", ffo, 16'sh0064);
		wr(4'h8, 32'h7);
		wr(4'h6, 32'h5);
		cyc(4);
		chk("ff with friction", ffo, 16'sh006b);
		$display("test loops done");
		wr(4'h0, 32'h1);
		cyc(8);
		chk("no restore mode 1", offs, 16'sh0000);
		wr(4'h0, 32'h4);
		cyc(8);
		chk("restore mode 4", offs, 16'sh0064);
		rd(4'h3, v);
		chk("offset read", v, 32'h64);
		@(posedge core_clk_i);
		base <= 16'sh7fbc;
		cyc(8);
		chk("setpoint clip", setp, 16'sh7ffc);
		@(posedge core_clk_i);
		base <= 16'shffce;
		cyc(8);
		chk("setpoint sum", setp, 16'sh0032);
		pins(1'b0, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i <= 12; i++) begin
			if (i == 12) begin
				miscompares++;
				results();
			end
			cyc(1);
			if (sv_wr === 1'b1)
				break;
		end
		chk("saved offset", sv_in, 16'sh0064);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		wr(4'h0, 32'h5);
		cyc(8);
		chk("both hold mode 5", offs, 16'sh0064);
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		cyc(8);
		chk("start withdrawn", offs, 16'sh0000);
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		$display("test modes 4 5 done");
		rst_seq();
		wr(4'h0, 32'h3);
		cyc(60);
		chk("restore mode 3", offs, 16'sh0064);
		wr(4'h4, 32'h32);
		cyc(8);
		chk("offset clamp", offs, 16'sh0032);
		wr(4'h0, 32'h0);
		cyc(8);
		chk("mode 0 clears", offs, 16'sh0000);
		rst_seq();
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		wr(4'h0, 32'h4);
		cyc(8);
		chk("both zero mode 4", offs, 16'sh0000);
		$display("test resets done");
		results();
	end
endmodule
